// File: logic/timer8_counter_compare_output.sv
/*
  8-bit timer/counter: counter unit, two compare channels, pin override, APB registers.
  assumes an APB master on clk; port_value/port_dir come from the port logic on clk.
*/
// What this block does
// - 8-bit up/down counter with count, direction, clear and top/bottom indications.
// - each timer tick clears, increments or decrements as the mode says.
// - clock select zero means no timer clock, counter stopped.
// - CPU reads and writes the counter at any time.
// - a CPU counter write beats a same-cycle clear or count.
// - mode selector: two low bits control A, high bit control B.
// - overflow flag set where the mode says; can request an interrupt.
// - counter compared for equality with both compare values continuously.
// - compare flag set one timer clock after a match; interrupt if enabled.
// - compare flag cleared when its interrupt is executed.
// - writing one to a flag bit clears it.
// - compare values buffered in PWM modes, not in normal or CTC.
// - buffered compare value copied to active only at top or bottom.
// - CPU compare access goes to buffer when buffered, else active.
// - force strobe acts like a match in non-PWM modes, no flag, no clear.
// - counter write blocks all matches in the next timer clock, even stopped.
// - output compare state kept when the waveform mode changes.
// - compare output mode unbuffered; acts from the next match on.
// - nonzero compare output mode lets output compare state drive the pin.
// - pin shows the value only when its direction is output.
// - compare output mode zero means no action at a match.
// - bottom is zero, max is 0xff, top is max or compare A.
// - modes: 0 normal, 2 CTC, 3/7 fast PWM, 1/5 phase correct.
`timescale 1ns/100ps
`default_nettype none
`include "timer8_defines.svh"

module timer8_counter_compare_output
  import timer8_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  irq_ack,
  output logic [2:0]       irq_request,
  input  wire logic [1:0]  port_value,
  input  wire logic [1:0]  port_dir,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe
);

  top_s             s_reg;
  top_s             s_next;
  logic             setup;
  logic             wr;
  logic             mapped;
  logic             timer_clock;
  logic [2:0]       waveform_mode;
  logic [2:0]       clock_select;
  mode_class_e      mode_class;
  logic [7:0]       top_value;
  logic             at_top;
  logic             at_bottom;
  logic [7:0]       cnt_step;
  logic             down_step;
  logic             ovf_step;
  logic             load_step;
  logic             fast_bottom;
  logic             wr_counter;
  logic [1:0][1:0]  com;
  logic [1:0][7:0]  compare_value;
  logic [1:0][7:0]  read_value;
  logic [1:0]       hit;
  logic [1:0]       oc;
  logic [2:0]       flag_set;
  logic [2:0]       flag_clr;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign waveform_mode = {s_reg.control_b[`CB_WM2], s_reg.control_a[1:0]};
  assign clock_select  = s_reg.control_b[2:0];
  assign com[0] = s_reg.control_a[`CA_COM_A_LSB+1:`CA_COM_A_LSB];
  assign com[1] = s_reg.control_a[`CA_COM_B_LSB+1:`CA_COM_B_LSB];

  always_comb begin
    case (waveform_mode)
      `WM_NORMAL:                  mode_class = mode_normal;
      `WM_CTC:                     mode_class = mode_ctc;
      `WM_FAST, `WM_FAST_TOPA:     mode_class = mode_fast;
      `WM_PHASE, `WM_PHASE_TOPA:   mode_class = mode_phase;
      default:                     mode_class = mode_normal;
    endcase
  end

  // top follows the live compare A value, so CTC top changes at once
  assign top_value = (waveform_mode == `WM_CTC || waveform_mode == `WM_FAST_TOPA ||
                      waveform_mode == `WM_PHASE_TOPA) ? compare_value[0] : `VAL_MAX;
  assign at_top    = s_reg.counter == top_value;
  assign at_bottom = s_reg.counter == `VAL_BOTTOM;

  timer8_prescaler u_prescaler (
    .clk          (clk),
    .rst          (rst),
    .clock_select (clock_select),
    .tick         (timer_clock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counting sequence

  always_comb begin
    cnt_step    = s_reg.counter + 8'h01;
    down_step   = 1'b0;
    ovf_step    = 1'b0;
    load_step   = 1'b0;
    fast_bottom = 1'b0;
    case (mode_class)
      mode_normal: begin
        ovf_step = s_reg.counter == `VAL_MAX;
      end
      mode_ctc: begin
        ovf_step = s_reg.counter == `VAL_MAX;
        if (at_top) begin
          cnt_step = `VAL_BOTTOM;
        end
      end
      mode_fast: begin
        ovf_step    = at_top;
        load_step   = at_top;
        fast_bottom = at_top;
        if (at_top) begin
          cnt_step = `VAL_BOTTOM;
        end
      end
      mode_phase: begin
        if (!s_reg.count_down) begin
          if (at_top && !at_bottom) begin
            load_step = 1'b1;
            down_step = 1'b1;
            cnt_step  = s_reg.counter - 8'h01;
          end
        end else if (at_bottom) begin
          ovf_step = 1'b1;
          load_step = top_value == `VAL_BOTTOM;
        end else begin
          down_step = 1'b1;
          cnt_step  = s_reg.counter - 8'h01;
        end
      end
      default: cnt_step = s_reg.counter;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare channels

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_channel
      timer8_compare_channel u_channel (
        .clk                  (clk),
        .rst                  (rst),
        .tick                 (timer_clock),
        .counter_value        (s_reg.counter),
        .mode_class           (mode_class),
        .count_down           (s_reg.count_down),
        .fast_bottom          (timer_clock && fast_bottom),
        .compare_load         (timer_clock && load_step),
        .block                (s_reg.block),
        .compare_output_mode  (com[ch]),
        .force_compare_strobe (s_reg.force_pulse[ch]),
        .wr_en                (wr && paddr == (ch == 0 ? `OFF_COMPARE_A : `OFF_COMPARE_B)),
        .wr_data              (pwdata[7:0]),
        .compare_value        (compare_value[ch]),
        .read_value           (read_value[ch]),
        .hit                  (hit[ch]),
        .compare_output_state (oc[ch])
      );
      // pin direction stays with the port; only the level is taken over
      assign pin_out[ch] = (com[ch] != 2'b00) ? oc[ch] : port_value[ch];
      assign pin_oe[ch]  = port_dir[ch];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus and registers

  assign setup      = psel && !penable;
  assign wr         = psel && penable && pwrite;
  assign wr_counter = wr && paddr == `OFF_COUNTER;
  assign pready     = 1'b1;
  assign prdata     = s_reg.rdata;
  assign pslverr    = s_reg.slverr;
  assign mapped     = paddr == `OFF_CONTROL_A || paddr == `OFF_CONTROL_B || paddr == `OFF_COUNTER ||
                      paddr == `OFF_COMPARE_A || paddr == `OFF_COMPARE_B || paddr == `OFF_FLAGS ||
                      paddr == `OFF_IRQ_ENABLE;

  assign flag_set = {hit[1], hit[0], timer_clock && ovf_step};
  // executed interrupt and one-written bit both clear; a same-cycle set wins
  assign flag_clr = irq_ack | ((wr && paddr == `OFF_FLAGS) ? pwdata[2:0] : 3'h0);
  assign irq_request = s_reg.flags & s_reg.irq_enable;

  always_comb begin
    s_next = s_reg;
    s_next.force_pulse = 2'b00;
    s_next.flags = flag_set | (s_reg.flags & ~flag_clr);
    if (timer_clock) begin
      s_next.counter    = cnt_step;
      s_next.count_down = down_step;
      s_next.block      = 1'b0;
    end
    if (setup) begin
      s_next.slverr = !mapped;
      case (paddr)
        `OFF_CONTROL_A:  s_next.rdata = {24'h000000, s_reg.control_a};
        `OFF_CONTROL_B:  s_next.rdata = {28'h0000000, s_reg.control_b};
        `OFF_COUNTER:    s_next.rdata = {24'h000000, s_reg.counter};
        `OFF_COMPARE_A:  s_next.rdata = {24'h000000, read_value[0]};
        `OFF_COMPARE_B:  s_next.rdata = {24'h000000, read_value[1]};
        `OFF_FLAGS:      s_next.rdata = {29'h00000000, s_reg.flags};
        `OFF_IRQ_ENABLE: s_next.rdata = {29'h00000000, s_reg.irq_enable};
        default:         s_next.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `OFF_CONTROL_A: s_next.control_a = pwdata[7:0];
        `OFF_CONTROL_B: begin
          s_next.control_b = pwdata[3:0];
          // force only acts in the non-PWM modes
          if (mode_class == mode_normal || mode_class == mode_ctc) begin
            s_next.force_pulse = {pwdata[`CB_FORCE_B], pwdata[`CB_FORCE_A]};
          end
        end
        `OFF_IRQ_ENABLE: s_next.irq_enable = pwdata[2:0];
        default: s_next.irq_enable = s_reg.irq_enable;
      endcase
    end
    if (wr_counter) begin
      // software must not write a value equal to a compare value; that match is lost
      s_next.counter = pwdata[7:0];
      s_next.block   = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.control_a <= `RST_CONTROL_A;
      s_reg.control_b <= `RST_CONTROL_B;
      s_reg.counter   <= `RST_COUNTER;
      s_reg.flags     <= `RST_FLAGS;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_counter_write;
    wr_counter;
  endsequence

  sequence s_blocked_tick;
    s_reg.block && timer_clock;
  endsequence

  property p_stopped;
    (clock_select == `CS_STOP) && !wr_counter |=> s_reg.counter == $past(s_reg.counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_cpu_wins;
    s_counter_write |=> s_reg.counter == $past(pwdata[7:0]) && s_reg.block;
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("counter write lost");

  // the block stands until a tick however long the timer is stopped; only a tick in the cycle right after the write is checked
  property p_block;
    s_counter_write ##1 s_blocked_tick |-> hit == 2'b00;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after counter write");

  property p_block_hold;
    s_reg.block && !timer_clock |=> s_reg.block;
  endproperty
  a_block_hold: assert property (p_block_hold) else $error("match block dropped before a tick");

  property p_flag_a;
    timer_clock && !s_reg.block && s_reg.counter == compare_value[0] |=> s_reg.flags[`FLAG_COMPARE_A];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("compare flag a not set");

  property p_w1c;
    wr && paddr == `OFF_FLAGS && pwdata[`FLAG_COMPARE_B] && !hit[1]
      |=> !s_reg.flags[`FLAG_COMPARE_B];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag b not cleared by write");

  property p_ack;
    irq_ack[`FLAG_OVERFLOW] && !flag_set[`FLAG_OVERFLOW] |=> !s_reg.flags[`FLAG_OVERFLOW];
  endproperty
  a_ack: assert property (p_ack) else $error("overflow flag not cleared by ack");

  property p_normal_wrap;
    waveform_mode == `WM_NORMAL && timer_clock && !wr_counter && s_reg.counter == `VAL_MAX
      |=> s_reg.counter == `VAL_BOTTOM && s_reg.flags[`FLAG_OVERFLOW];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode wrap wrong");

  property p_ctc_clear;
    waveform_mode == `WM_CTC && timer_clock && !wr_counter && s_reg.counter == compare_value[0]
      |=> s_reg.counter == `VAL_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear at top");

  property p_pin;
    (com[0] != 2'b00 |-> pin_out[0] == oc[0]) and (pin_oe == port_dir);
  endproperty
  a_pin: assert property (p_pin) else $error("pin override wrong");

  property p_force_no_flag;
    s_reg.force_pulse[0] && !hit[0] && !irq_ack[`FLAG_COMPARE_A]
      |=> s_reg.flags[`FLAG_COMPARE_A] == $past(s_reg.flags[`FLAG_COMPARE_A]);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

endmodule // timer8_counter_compare_output
`default_nettype wire

// File: include/timer8_defines.svh
/*
  register offsets, field positions, reset values and mode codes of the 8-bit timer.
  assumes nothing; included by bare name wherever a constant is needed.
*/
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

`define OFF_CONTROL_A    8'h00
`define OFF_CONTROL_B    8'h04
`define OFF_COUNTER      8'h08
`define OFF_COMPARE_A    8'h0c
`define OFF_COMPARE_B    8'h10
`define OFF_FLAGS        8'h14
`define OFF_IRQ_ENABLE   8'h18

`define CA_COM_A_LSB     6
`define CA_COM_B_LSB     4
`define CB_FORCE_A       7
`define CB_FORCE_B       6
`define CB_WM2           3
`define FLAG_OVERFLOW    0
`define FLAG_COMPARE_A   1
`define FLAG_COMPARE_B   2

`define RST_CONTROL_A    8'h00
`define RST_CONTROL_B    4'h0
`define RST_COUNTER      8'h00
`define RST_COMPARE      8'h00
`define RST_FLAGS        3'h0

`define VAL_BOTTOM       8'h00
`define VAL_MAX          8'hff

`define WM_NORMAL        3'h0
`define WM_PHASE         3'h1
`define WM_CTC           3'h2
`define WM_FAST          3'h3
`define WM_PHASE_TOPA    3'h5
`define WM_FAST_TOPA     3'h7

`define CS_STOP          3'h0
`define PRESCALE_W       10
`define PRE_MASK_8       10'h007
`define PRE_MASK_32      10'h01f
`define PRE_MASK_64      10'h03f
`define PRE_MASK_128     10'h07f
`define PRE_MASK_256     10'h0ff
`define PRE_MASK_1024    10'h3ff

`endif

// File: include/timer8_pkg.sv
/*
  types of the 8-bit timer: mode classes and the state structs of each module.
  assumes timer8_defines.svh on the include path.
*/
`include "timer8_defines.svh"

package timer8_pkg;

  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_ctc    = 2'b01,
    mode_fast   = 2'b10,
    mode_phase  = 2'b11
  } mode_class_e;

  typedef struct packed {
    logic [`PRESCALE_W-1:0] div;
  } prescaler_s;

  typedef struct packed {
    logic [7:0] active;
    logic [7:0] buffer;
    logic       oc;
  } channel_s;

  typedef struct packed {
    logic [7:0]  control_a;
    logic [3:0]  control_b;
    logic [7:0]  counter;
    logic        count_down;
    logic        block;
    logic [2:0]  flags;
    logic [2:0]  irq_enable;
    logic [1:0]  force_pulse;
    logic [31:0] rdata;
    logic        slverr;
  } top_s;

endpackage

// File: logic/timer8_prescaler.sv
/*
  divider making the one-cycle timer clock enable from clk.
  assumes clock_select comes from logic on clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer8_defines.svh"

module timer8_prescaler
  import timer8_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] clock_select,
  output logic            tick
);

  prescaler_s             s_reg;
  prescaler_s             s_next;
  logic [`PRESCALE_W-1:0] mask;

  always_comb begin
    s_next     = s_reg;
    s_next.div = s_reg.div + `PRESCALE_W'(1);
    case (clock_select)
      3'h2:    mask = `PRE_MASK_8;
      3'h3:    mask = `PRE_MASK_32;
      3'h4:    mask = `PRE_MASK_64;
      3'h5:    mask = `PRE_MASK_128;
      3'h6:    mask = `PRE_MASK_256;
      3'h7:    mask = `PRE_MASK_1024;
      default: mask = '0;
    endcase
  end

  // no tick at all while stopped
  assign tick = (clock_select != `CS_STOP) && ((s_reg.div & mask) == mask);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // timer8_prescaler
`default_nettype wire

// File: logic/timer8_compare_channel.sv
/*
  one output compare channel: compare value with buffer, comparator, output compare state.
  assumes all inputs come from logic on clk; tick is a one-cycle enable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer8_defines.svh"

module timer8_compare_channel
  import timer8_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic [7:0]  counter_value,
  input  wire mode_class_e mode_class,
  input  wire logic        count_down,
  input  wire logic        fast_bottom,
  input  wire logic        compare_load,
  input  wire logic        block,
  input  wire logic [1:0]  compare_output_mode,
  input  wire logic        force_compare_strobe,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  output logic [7:0]       compare_value,
  output logic [7:0]       read_value,
  output logic             hit,
  output logic             compare_output_state
);

  channel_s s_reg;
  channel_s s_next;
  logic     buffered;

  assign buffered = (mode_class == mode_fast) || (mode_class == mode_phase);
  assign hit = tick && !block && (counter_value == s_reg.active);
  assign compare_value = s_reg.active;
  assign compare_output_state = s_reg.oc;
  assign read_value = buffered ? s_reg.buffer : s_reg.active;

  always_comb begin
    s_next = s_reg;
    if (buffered && compare_load) begin
      s_next.active = s_reg.buffer;
    end
    if (wr_en) begin
      s_next.buffer = wr_data;
      if (!buffered) begin
        s_next.active = wr_data;
      end
    end
    // mode is read live each cycle; oc itself is never reset by a mode change
    case (mode_class)
      mode_normal, mode_ctc: begin
        if (hit || force_compare_strobe) begin
          case (compare_output_mode)
            2'b01:   s_next.oc = !s_reg.oc;
            2'b10:   s_next.oc = 1'b0;
            2'b11:   s_next.oc = 1'b1;
            default: s_next.oc = s_reg.oc;
          endcase
        end
      end
      mode_fast: begin
        // bottom wins when compare equals top, giving a steady level
        if (fast_bottom && compare_output_mode[1]) begin
          s_next.oc = !compare_output_mode[0];
        end else if (hit) begin
          case (compare_output_mode)
            2'b01:   s_next.oc = !s_reg.oc;
            2'b10:   s_next.oc = 1'b0;
            2'b11:   s_next.oc = 1'b1;
            default: s_next.oc = s_reg.oc;
          endcase
        end
      end
      mode_phase: begin
        if (hit && compare_output_mode[1]) begin
          s_next.oc = count_down ^ compare_output_mode[0];
        end
      end
      default: s_next.oc = s_reg.oc;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= {`RST_COMPARE, `RST_COMPARE, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // timer8_compare_channel
`default_nettype wire

// File: testbench/tb.sv
/*
  self-checking bench for the 8-bit timer: apb tasks and directed register sequences.
  assumes timer8_pkg compiled first and timer8_defines.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "timer8_defines.svh"

module tb
  import timer8_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  irq_ack;
  logic [2:0]  irq_request;
  logic [1:0]  port_value;
  logic [1:0]  port_dir;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          checks;

  timer8_counter_compare_output timer8_counter_compare_output_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
    .irq_request(irq_request), .port_value(port_value), .port_dir(port_dir),
    .pin_out(pin_out), .pin_oe(pin_oe));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // the master holds the request until pready is seen; only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // counter read checked against a window; an unknown value counts as a mismatch
  task automatic cchk(input string nm, input logic [31:0] lo, input logic [31:0] hi);
    xfer(1'b0, `OFF_COUNTER, 32'h0);
    checks++;
    if ((rd >= lo && rd <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, rd);
    end
  endtask

  task automatic run(input int n);
    xfer(1'b1, `OFF_CONTROL_B, 32'h01);
    repeat (n) @(posedge clk);
    xfer(1'b1, `OFF_CONTROL_B, 32'h00);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // generous: the sequence needs well under 1000 cycles
  initial begin
    #(4 * 5000);
    error_cnt++;
    conclude();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; irq_ack = 3'h0; port_value = 2'b10; port_dir = 2'b01;
    error_cnt = 0; checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;

    rchk("control_a", `OFF_CONTROL_A, 32'h0);
    rchk("counter", `OFF_COUNTER, 32'h0);
    rchk("flags", `OFF_FLAGS, 32'h0);
    rchk("unmapped", 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test reset done");

    xfer(1'b1, `OFF_COUNTER, 32'h10);
    repeat (10) @(posedge clk);
    rchk("stopped counter", `OFF_COUNTER, 32'h10);
    $display("test stopped done");

    // toggle on compare A, compare B left to the port
    xfer(1'b1, `OFF_CONTROL_A, 32'h40);
    xfer(1'b1, `OFF_CONTROL_B, 32'h80);
    repeat (2) @(posedge clk);
    chk("forced pin", 32'h3, {30'h0, pin_out});
    chk("pin oe", 32'h1, {30'h0, pin_oe});
    rchk("force flags", `OFF_FLAGS, 32'h0);
    rchk("force counter", `OFF_COUNTER, 32'h10);
    $display("test force done");

    xfer(1'b1, `OFF_COMPARE_B, 32'h30);
    xfer(1'b1, `OFF_CONTROL_A, 32'h43);
    xfer(1'b1, `OFF_COMPARE_B, 32'h40);
    rchk("buffer", `OFF_COMPARE_B, 32'h40);
    xfer(1'b1, `OFF_CONTROL_A, 32'h40);
    rchk("active", `OFF_COMPARE_B, 32'h30);
    chk("oc kept", 32'h1, {31'h0, pin_out[0]});
    $display("test buffer done");

    xfer(1'b1, `OFF_COMPARE_A, 32'h05);
    xfer(1'b1, `OFF_COMPARE_B, 32'h00);
    xfer(1'b1, `OFF_IRQ_ENABLE, 32'h7);
    xfer(1'b1, `OFF_COUNTER, 32'h00);
    run(20);
    rchk("match flags", `OFF_FLAGS, 32'h2);
    chk("irq", 32'h2, {29'h0, irq_request});
    chk("oc toggled", 32'h0, {31'h0, pin_out[0]});
    cchk("count", 32'h10, 32'h20);
    $display("test match done");

    xfer(1'b1, `OFF_CONTROL_A, 32'h00);
    chk("port pin", 32'h2, {30'h0, pin_out});
    xfer(1'b1, `OFF_COUNTER, 32'hf0);
    run(25);
    rchk("wrap flags", `OFF_FLAGS, 32'h7);
    xfer(1'b1, `OFF_FLAGS, 32'h5);
    rchk("cleared flags", `OFF_FLAGS, 32'h2);
    @(posedge clk);
    irq_ack <= 3'b010;
    @(posedge clk);
    irq_ack <= 3'b000;
    rchk("acked flags", `OFF_FLAGS, 32'h0);
    $display("test overflow done");

    xfer(1'b1, `OFF_CONTROL_B, 32'h01);
    xfer(1'b1, `OFF_COUNTER, 32'h80);
    xfer(1'b1, `OFF_CONTROL_B, 32'h00);
    cchk("written count", 32'h80, 32'h84);
    $display("test priority done");

    // ctc: top is compare a, so the count never leaves 0..5 and never overflows
    xfer(1'b1, `OFF_CONTROL_A, 32'h02);
    xfer(1'b1, `OFF_COUNTER, 32'h01);
    run(40);
    cchk("ctc count", 32'h00, 32'h05);
    rchk("ctc flags", `OFF_FLAGS, 32'h6);
    $display("test ctc done");

    // fast pwm: buffer reaches the active compare only at top
    xfer(1'b1, `OFF_FLAGS, 32'h7);
    xfer(1'b1, `OFF_CONTROL_A, 32'h03);
    xfer(1'b1, `OFF_COMPARE_B, 32'h20);
    xfer(1'b1, `OFF_COUNTER, 32'hfe);
    run(2);
    rchk("fast flags", `OFF_FLAGS, 32'h1);
    xfer(1'b1, `OFF_CONTROL_A, 32'h00);
    rchk("loaded", `OFF_COMPARE_B, 32'h20);
    $display("test fast done");

    // phase correct: turns round at top, no overflow there
    xfer(1'b1, `OFF_FLAGS, 32'h7);
    xfer(1'b1, `OFF_CONTROL_A, 32'h01);
    xfer(1'b1, `OFF_COUNTER, 32'hfd);
    run(2);
    cchk("phase count", 32'hf0, 32'hfe);
    rchk("phase flags", `OFF_FLAGS, 32'h0);
    $display("test phase done");
    conclude();
  end
endmodule // tb

`default_nettype wire
